// ### common/kl_pkg.sv
// Constants and types for the keypad lock and unlock control block
// Notes on behaviour
// - While locking is enabled, the first release code names the event that must be seen first to unlock.
// - The second release code names the event that must follow the first one to complete the unlock.
// - For key events, polarity bit 7 set selects a press, and a key release never matches any code.
// - For general input or logic events, polarity 0 matches the inactive and 1 the active event.
// - An event matching the lock trigger code locks the keypad.
// - Matching the lock trigger event sets the sticky lock interrupt flag.
// - While locked with a nonzero mask time, one event raises the event interrupt and starts the mask timer, and further events raise none until it expires or the keypad unlocks.
// - The 5-bit mask time is disabled at zero and otherwise counts that many seconds, 1 to 31.
// - After the first release event, a missing second event within the window, or any other event, returns to full lock.
// - The 3-bit unlock window is disabled at zero and otherwise lasts that many seconds, 1 to 7.
// - Bit 0 of the lock control register enables the lock function and its other bits are reserved.
package kl_pkg;
  // Register offsets
  localparam logic [7:0] KL_ADDR_FIRST = 8'h33;
  localparam logic [7:0] KL_ADDR_SECOND = 8'h34;
  localparam logic [7:0] KL_ADDR_TRIGGER = 8'h35;
  localparam logic [7:0] KL_ADDR_TIMING = 8'h36;
  localparam logic [7:0] KL_ADDR_CONTROL = 8'h37;
  // Field positions
  localparam int KL_POL_BIT = 7;
  localparam int KL_MASK_LSB = 3;
  localparam int KL_MASK_MSB = 7;
  localparam int KL_WIN_MSB = 2;
  localparam int KL_EN_BIT = 0;
  // Reset values
  localparam logic [7:0] KL_CODE_RST = 8'h00;
  localparam logic [7:0] KL_TIMING_RST = 8'h00;
  localparam logic KL_EN_RST = 1'b0;
  // Timing
  localparam int KL_CLK_PERIOD_NS = 100;
  localparam int KL_TICK_NS = 1000000000;
  localparam int KL_TICK_CYCLES = KL_TICK_NS / KL_CLK_PERIOD_NS;
  localparam int KL_PRE_W = 24;

  typedef enum logic [1:0] {
    KL_OPEN,
    KL_LOCKED,
    KL_HALF
  } kl_mode_e;
endpackage

// ### rtl/kl_lock_ctrl.sv
// Keypad lock and unlock control with its five registers
module kl_lock_ctrl #(
  parameter int TICK_CYCLES = kl_pkg::KL_TICK_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Register access
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Incoming events
  input wire logic EVT_VALID,
  input wire logic [6:0] EVT_CODE,
  input wire logic EVT_STATE,
  input wire logic EVT_IS_KEY,
  // Status
  input wire logic LOCK_INT_CLR,
  output logic LOCK_INT,
  output logic EVENT_INT,
  output logic LOCKED
);

  typedef struct packed {
    kl_pkg::kl_mode_e mode;
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] trigger;
    logic [7:0] timing;
    logic en;
    logic [kl_pkg::KL_PRE_W-1:0] pre;
    logic [4:0] mask_cnt;
    logic [2:0] win_cnt;
    logic lock_int;
    logic evt_int;
    logic locked;
    logic [7:0] rdata;
  } kl_state_s;

  kl_state_s q;
  kl_state_s d;

  localparam logic [kl_pkg::KL_PRE_W-1:0] PRE_LAST = kl_pkg::KL_PRE_W'(TICK_CYCLES - 1);

  function automatic logic code_match(logic [7:0] c, logic [6:0] e, logic s, logic k);
    return (c[6:0] == e) && (c[kl_pkg::KL_POL_BIT] == s) && !(k && !s);
  endfunction

  logic tick;
  logic m_first;
  logic m_second;
  logic m_trig;
  logic ctl_wr;
  logic [4:0] mask_field;
  logic [2:0] win_field;

  assign tick = (q.pre == PRE_LAST);
  assign m_first = code_match(q.first, EVT_CODE, EVT_STATE, EVT_IS_KEY);
  assign m_second = code_match(q.second, EVT_CODE, EVT_STATE, EVT_IS_KEY);
  assign m_trig = code_match(q.trigger, EVT_CODE, EVT_STATE, EVT_IS_KEY);
  assign ctl_wr = REG_WR && (REG_ADDR == kl_pkg::KL_ADDR_CONTROL);
  assign mask_field = q.timing[kl_pkg::KL_MASK_MSB:kl_pkg::KL_MASK_LSB];
  assign win_field = q.timing[kl_pkg::KL_WIN_MSB:0];

  always_comb begin
    d = q;
    d.evt_int = 1'b0;
    // Register writes
    if (REG_WR) begin
      if (REG_ADDR == kl_pkg::KL_ADDR_FIRST) begin
        d.first = REG_WDATA;
      end else if (REG_ADDR == kl_pkg::KL_ADDR_SECOND) begin
        d.second = REG_WDATA;
      end else if (REG_ADDR == kl_pkg::KL_ADDR_TRIGGER) begin
        d.trigger = REG_WDATA;
      end else if (REG_ADDR == kl_pkg::KL_ADDR_TIMING) begin
        d.timing = REG_WDATA;
      end else if (REG_ADDR == kl_pkg::KL_ADDR_CONTROL) begin
        d.en = REG_WDATA[kl_pkg::KL_EN_BIT];
      end
    end
    // Register reads, reserved bits zero
    if (REG_RD) begin
      if (REG_ADDR == kl_pkg::KL_ADDR_FIRST) begin
        d.rdata = q.first;
      end else if (REG_ADDR == kl_pkg::KL_ADDR_SECOND) begin
        d.rdata = q.second;
      end else if (REG_ADDR == kl_pkg::KL_ADDR_TRIGGER) begin
        d.rdata = q.trigger;
      end else if (REG_ADDR == kl_pkg::KL_ADDR_TIMING) begin
        d.rdata = q.timing;
      end else if (REG_ADDR == kl_pkg::KL_ADDR_CONTROL) begin
        d.rdata = {7'h00, q.en};
      end else begin
        d.rdata = 8'h00;
      end
    end
    // One-second prescaler and timers
    d.pre = tick ? '0 : q.pre + 1'b1;
    if (tick && q.mask_cnt != 5'h00) begin
      d.mask_cnt = q.mask_cnt - 5'h01;
    end
    if (tick && q.win_cnt != 3'h0) begin
      d.win_cnt = q.win_cnt - 3'h1;
    end
    // Event interrupt gating
    if (EVT_VALID) begin
      if (q.mode == kl_pkg::KL_OPEN) begin
        d.evt_int = 1'b1;
      end else if (mask_field != 5'h00 && q.mask_cnt == 5'h00) begin
        d.evt_int = 1'b1;
        d.mask_cnt = mask_field;
      end
    end
    // Lock state
    if (!d.en) begin
      d.mode = kl_pkg::KL_OPEN;
      d.win_cnt = 3'h0;
      d.mask_cnt = 5'h00;
    end else if (!q.en) begin
      d.mode = kl_pkg::KL_LOCKED;
      d.win_cnt = 3'h0;
    end else if (EVT_VALID && m_trig) begin
      d.mode = kl_pkg::KL_LOCKED;
      d.lock_int = 1'b1;
      d.win_cnt = 3'h0;
    end else begin
      case (q.mode)
        kl_pkg::KL_LOCKED: begin
          if (EVT_VALID && m_first) begin
            d.mode = kl_pkg::KL_HALF;
            d.win_cnt = win_field;
          end
        end
        kl_pkg::KL_HALF: begin
          if (EVT_VALID && m_second) begin
            d.mode = kl_pkg::KL_OPEN;
            d.mask_cnt = 5'h00;
          end else if (EVT_VALID) begin
            d.mode = kl_pkg::KL_LOCKED;
          end else if (tick && q.win_cnt == 3'h1) begin
            d.mode = kl_pkg::KL_LOCKED;
          end
        end
        default: begin
        end
      endcase
    end
    // Sticky flag, set wins over clear
    if (LOCK_INT_CLR && !(d.en && q.en && EVT_VALID && m_trig)) begin
      d.lock_int = 1'b0;
    end
    d.locked = (d.mode != kl_pkg::KL_OPEN);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      q <= '{mode: kl_pkg::KL_OPEN, first: kl_pkg::KL_CODE_RST, second: kl_pkg::KL_CODE_RST,
             trigger: kl_pkg::KL_CODE_RST, timing: kl_pkg::KL_TIMING_RST,
             en: kl_pkg::KL_EN_RST, pre: '0, mask_cnt: 5'h00, win_cnt: 3'h0,
             lock_int: 1'b0, evt_int: 1'b0, locked: 1'b0, rdata: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA = q.rdata;
  assign LOCK_INT = q.lock_int;
  assign EVENT_INT = q.evt_int;
  assign LOCKED = q.locked;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  property p_first;
    q.mode == kl_pkg::KL_LOCKED && q.en && EVT_VALID && m_first && !m_trig && !ctl_wr
      |=> q.mode == kl_pkg::KL_HALF && LOCKED;
  endproperty
  a_first: assert property (p_first) else $error("first release event not taken");

  property p_second;
    q.mode == kl_pkg::KL_HALF && q.en && EVT_VALID && m_second && !m_trig && !ctl_wr
      |=> q.mode == kl_pkg::KL_OPEN && !LOCKED;
  endproperty
  a_second: assert property (p_second) else $error("second release event not taken");

  property p_release;
    EVT_VALID && EVT_IS_KEY && !EVT_STATE |-> !m_first && !m_second && !m_trig;
  endproperty
  a_release: assert property (p_release) else $error("key release matched a code");

  property p_trigger;
    q.en && EVT_VALID && m_trig && !ctl_wr |=> LOCK_INT && q.mode == kl_pkg::KL_LOCKED;
  endproperty
  a_trigger: assert property (p_trigger) else $error("lock event did not lock");

  property p_masked;
    q.locked && EVT_VALID && q.mask_cnt != 5'h00 && !ctl_wr |=> !EVENT_INT;
  endproperty
  a_masked: assert property (p_masked) else $error("event interrupt not masked");

  property p_mask_load;
    q.locked && q.en && EVT_VALID && q.mask_cnt == 5'h00 && mask_field != 5'h00 && !ctl_wr
      && !(q.mode == kl_pkg::KL_HALF && m_second && !m_trig)
      |=> EVENT_INT && q.mask_cnt == $past(mask_field);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask timer not loaded");

  property p_other;
    q.mode == kl_pkg::KL_HALF && q.en && EVT_VALID && !m_second && !ctl_wr
      |=> q.mode == kl_pkg::KL_LOCKED;
  endproperty
  a_other: assert property (p_other) else $error("other event did not relock");

  property p_window;
    q.mode == kl_pkg::KL_HALF && q.en && !EVT_VALID && !ctl_wr && tick && q.win_cnt == 3'h1
      |=> q.mode == kl_pkg::KL_LOCKED;
  endproperty
  a_window: assert property (p_window) else $error("unlock window did not expire");

  property p_disabled;
    !q.en |-> q.mode == kl_pkg::KL_OPEN && !LOCKED;
  endproperty
  a_disabled: assert property (p_disabled) else $error("locked while disabled");

  property p_tick;
    tick |=> q.pre == '0 ##1 q.pre == kl_pkg::KL_PRE_W'(1);
  endproperty
  a_tick: assert property (p_tick) else $error("prescaler did not wrap");

endmodule // kl_lock_ctrl

// ### bench/test_keypad_lock_unlock_control.sv
// Self-checking testbench for the keypad lock and unlock control block
module test_keypad_lock_unlock_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset_n, reg_wr, reg_rd, evt_valid, evt_state, evt_is_key, lock_int_clr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] evt_code;
  logic lock_int, event_int, locked;
  int mismatches, check_count, nint;

  kl_lock_ctrl #(.TICK_CYCLES(20)) DUT (.CORE_CLK(core_clk), .RESET_N(reset_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .EVT_VALID(evt_valid), .EVT_CODE(evt_code), .EVT_STATE(evt_state),
    .EVT_IS_KEY(evt_is_key), .LOCK_INT_CLR(lock_int_clr), .LOCK_INT(lock_int),
    .EVENT_INT(event_int), .LOCKED(locked));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    chk("read data", e, reg_rdata);
  endtask

  // One event pulse, then count event interrupt pulses that follow
  task automatic evt(input logic [6:0] c, input logic s, input logic k);
    evt_code = c;
    evt_state = s;
    evt_is_key = k;
    evt_valid = 1'b1;
    nint = 0;
    cyc(1);
    evt_valid = 1'b0;
    if (event_int === 1'b1) nint++;
    repeat (2) begin
      cyc(1);
      if (event_int === 1'b1) nint++;
    end
  endtask

  task automatic t_regs;
    for (int a = 8'h33; a <= 8'h38; a++) rd(8'(a), 8'h00);
    wr(kl_pkg::KL_ADDR_CONTROL, 8'hFF);
    rd(kl_pkg::KL_ADDR_CONTROL, 8'h01);
    wr(kl_pkg::KL_ADDR_CONTROL, 8'h00);
    wr(8'h38, 8'h5A);
    rd(8'h38, 8'h00);
    evt(7'h40, 1'b1, 1'b1);
    chk("open pulses", 8'h01, 8'(nint));
    chk("open locked", 8'h00, 8'(locked));
  endtask

  task automatic t_unlock;
    wr(kl_pkg::KL_ADDR_FIRST, 8'h12);
    wr(kl_pkg::KL_ADDR_SECOND, 8'h05);
    wr(kl_pkg::KL_ADDR_TRIGGER, 8'hC4);
    wr(kl_pkg::KL_ADDR_TIMING, 8'h07);
    rd(kl_pkg::KL_ADDR_TIMING, 8'h07);
    wr(kl_pkg::KL_ADDR_CONTROL, 8'h01);
    chk("lock on enable", 8'h01, 8'(locked));
    evt(7'h40, 1'b1, 1'b1);
    chk("masked pulses", 8'h00, 8'(nint));
    evt(7'h12, 1'b0, 1'b1);
    evt(7'h05, 1'b0, 1'b0);
    chk("release no unlock", 8'h01, 8'(locked));
    wr(kl_pkg::KL_ADDR_FIRST, 8'h92);
    evt(7'h12, 1'b1, 1'b1);
    evt(7'h05, 1'b1, 1'b0);
    evt(7'h05, 1'b0, 1'b0);
    chk("other event relock", 8'h01, 8'(locked));
    evt(7'h12, 1'b1, 1'b1);
    evt(7'h05, 1'b0, 1'b0);
    chk("unlocked", 8'h00, 8'(locked));
    evt(7'h40, 1'b1, 1'b1);
    chk("pulses after unlock", 8'h01, 8'(nint));
  endtask

  task automatic t_timeout;
    wr(kl_pkg::KL_ADDR_TIMING, 8'h00);
    wr(kl_pkg::KL_ADDR_CONTROL, 8'h00);
    wr(kl_pkg::KL_ADDR_CONTROL, 8'h01);
    evt(7'h12, 1'b1, 1'b1);
    cyc(45);
    evt(7'h05, 1'b0, 1'b0);
    chk("window disabled", 8'h00, 8'(locked));
    wr(kl_pkg::KL_ADDR_TIMING, 8'h01);
    wr(kl_pkg::KL_ADDR_CONTROL, 8'h00);
    wr(kl_pkg::KL_ADDR_CONTROL, 8'h01);
    evt(7'h12, 1'b1, 1'b1);
    cyc(45);
    evt(7'h05, 1'b0, 1'b0);
    chk("window expired", 8'h01, 8'(locked));
  endtask

  task automatic t_trigger_mask;
    wr(kl_pkg::KL_ADDR_TIMING, 8'h17);
    evt(7'h12, 1'b1, 1'b1);
    evt(7'h44, 1'b1, 1'b0);
    chk("trigger flag", 8'h01, 8'(lock_int));
    evt(7'h05, 1'b0, 1'b0);
    chk("half reset by trigger", 8'h01, 8'(locked));
    lock_int_clr = 1'b1;
    cyc(1);
    lock_int_clr = 1'b0;
    cyc(1);
    chk("flag cleared", 8'h00, 8'(lock_int));
    evt(7'h12, 1'b1, 1'b1);
    evt(7'h05, 1'b0, 1'b0);
    chk("unlocked again", 8'h00, 8'(locked));
    evt(7'h44, 1'b1, 1'b0);
    chk("trigger locks", 8'h01, 8'(locked));
    chk("trigger flag open", 8'h01, 8'(lock_int));
    cyc(45);
    evt(7'h40, 1'b1, 1'b1);
    chk("first masked event", 8'h01, 8'(nint));
    evt(7'h41, 1'b1, 1'b1);
    chk("second masked event", 8'h00, 8'(nint));
    cyc(45);
    evt(7'h42, 1'b1, 1'b1);
    chk("after mask expiry", 8'h01, 8'(nint));
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    $display("unexpected run length expected %h seen %h", 8'h00, 8'h01);
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    evt_valid = 1'b0;
    evt_code = 7'h00;
    evt_state = 1'b0;
    evt_is_key = 1'b0;
    lock_int_clr = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    t_regs();
    t_unlock();
    t_timeout();
    t_trigger_mask();
    complete_run();
  end
endmodule // test_keypad_lock_unlock_control
